// ===== hws_fault_supervisor.sv
// Fault supervisor and startup sequencer with Wishbone registers.
// Assumes analog comparators feed level inputs from outside this clock.
//
// Implementation choices: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module hws_fault_supervisor #(
  parameter int DLY_CYC = hws_pkg::DLY_US * 1000 / hws_pkg::CLK_NS,
  parameter int SELF_CYC = hws_pkg::SELF_US * 1000 / hws_pkg::CLK_NS,
  parameter int MOD_CYC0 = hws_pkg::MOD_US[0] * 1000 / hws_pkg::CLK_NS,
  parameter int MOD_CYC1 = hws_pkg::MOD_US[1] * 1000 / hws_pkg::CLK_NS,
  parameter int MOD_CYC2 = hws_pkg::MOD_US[2] * 1000 / hws_pkg::CLK_NS,
  parameter int MOD_CYC3 = hws_pkg::MOD_US[3] * 1000 / hws_pkg::CLK_NS
) (
  input wire logic clk_i, // 100 MHz clock
  input wire logic rst_n_i, // Async reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Ack
  input wire logic enable_lockout_input_i, // Enable above threshold
  input wire logic vin_over_i, // Input above overvoltage limit
  input wire logic [2:0] su_over_i, // Above startup limits
  input wire logic oc_mod_i, // Above moderate threshold
  input wire logic oc_sev_i, // Above severe threshold
  input wire logic oc_safe_i, // Above safe threshold
  input wire logic rocp_ok_i, // Program resistor in range
  input wire logic temp_fault_i, // Above fault temperature
  input wire logic temp_warn_i, // Above warning temperature
  input wire logic vout_good_i, // Output above good threshold
  input wire logic fet_enh_i, // Transistor fully enhanced
  input wire logic css_low_i, // Soft-start cap discharged
  input wire logic vout_low_i, // Output below self-check level
  input wire logic init_done_i, // Address read, boost charged
  input wire logic fault_i, // Fault line level
  output logic fault_o, // Fault line drive value
  output logic fault_oe_o, // Fault drive enable, low drives
  output logic supply_ok_out_o, // Power-good drive value
  output logic supply_ok_out_oe_o, // Power-good enable, low drives
  output logic fet_on_o, // Pass transistor on
  output logic softstart_capacitor_dis_o, // Discharge soft-start cap
  output logic input_overvolt_guard_en_o, // Overvoltage guard on
  output logic [7:0] ovp_limit_o, // Overvoltage limit to DAC
  output logic [1:0] su_sel_o, // Startup limit select
  output logic [2:0] sev_ratio_o // Severe ratio to analog
);
  // ****************************************
  // Behaviour notes
  // ****************************************
  // Pin levels reach the logic three to four cycles late.
  // A fault drops the sequencer from any state but init to idle at once.
  // Only a falling enable or a restart write opens the latch.

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rsync_ff; // Reset synchroniser
  logic rst_n; // Released reset
  hws_pkg::hws_regs_t q_ff; // All state
  hws_pkg::hws_regs_t nxt_q; // Next state
  logic [hws_pkg::NIN-1:0] pins; // Raw inputs
  logic [hws_pkg::NIN-1:0] f; // Filtered inputs
  logic [hws_pkg::NC-1:0] set_c; // Fault sources this cycle
  logic wr, rd, clr, run, on_pg; // Decodes
  logic [31:0] wmask; // Byte lane mask

  // Two flops so release never meets a clock edge mid-way
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsync_ff <= 2'h0;
    end else begin
      rsync_ff <= {rsync_ff[0], 1'b1};
    end
  end
  assign rst_n = rsync_ff[1];

  // Moderate timeout for a select code
  function automatic logic [19:0] mod_lim(input logic [1:0] s);
    logic [19:0] r;
    r = 20'(MOD_CYC3);
    unique case (s)
      2'h0: r = 20'(MOD_CYC0);
      2'h1: r = 20'(MOD_CYC1);
      2'h2: r = 20'(MOD_CYC2);
      2'h3: r = 20'(MOD_CYC3);
    endcase
    return r;
  endfunction

  // Startup comparator for the host choice
  function automatic logic su_pick(input logic [2:0] v, input logic [1:0] s);
    logic r;
    r = v[2];
    if (s == 2'h0) begin
      r = v[0];
    end else if (s == 2'h1) begin
      r = v[1];
    end
    return r;
  endfunction

  assign pins = {fault_i, init_done_i, vout_low_i, css_low_i, fet_enh_i,
    vout_good_i, temp_warn_i, temp_fault_i, rocp_ok_i, oc_safe_i,
    oc_sev_i, oc_mod_i, su_over_i, vin_over_i, enable_lockout_input_i};
  assign f = q_ff.flt;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    nxt_q = q_ff;

    // Three-stage sync; a change counts once stages two and three agree
    nxt_q.s1 = pins;
    nxt_q.s2 = q_ff.s1;
    nxt_q.s3 = q_ff.s2;
    for (int i = 0; i < hws_pkg::NIN; i++) begin
      if (q_ff.s2[i] == q_ff.s3[i]) begin
        nxt_q.flt[i] = q_ff.s3[i];
      end
    end

    // ****************************************
    // Register bus
    // ****************************************
    // Bus decode, one answer per request
    wr = wb_cyc_i & wb_stb_i & ~q_ff.ack & wb_we_i;
    rd = wb_cyc_i & wb_stb_i & ~q_ff.ack & ~wb_we_i;
    nxt_q.ack = wb_cyc_i & wb_stb_i & ~q_ff.ack;
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    clr = 1'b0;
    if (wr && wb_adr_i == hws_pkg::ADR_CTRL) begin
      if (wb_sel_i[0]) begin
        nxt_q.ovp_en = wb_dat_i[hws_pkg::CB_OVP_EN];
        nxt_q.su_sel = wb_dat_i[hws_pkg::CB_SU_SEL +: 2];
        nxt_q.mod_sel = wb_dat_i[hws_pkg::CB_MOD_SEL +: 2];
        nxt_q.sev_to = wb_dat_i[hws_pkg::CB_SEV_TO];
        clr = wb_dat_i[hws_pkg::CB_RESTART];
      end
      if (wb_sel_i[1]) begin
        nxt_q.ratio = wb_dat_i[hws_pkg::CB_RATIO +: 3];
      end
    end

    if (wr && wb_adr_i == hws_pkg::ADR_OVP) begin
      nxt_q.ovp_lim = (q_ff.ovp_lim & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
    end

    // ****************************************
    // Protection tiers
    // ****************************************
    // Falling enable also clears the latch
    nxt_q.en_prev = f[hws_pkg::IN_EN];
    if (q_ff.en_prev && !f[hws_pkg::IN_EN]) begin
      clr = 1'b1;
    end

    run = q_ff.st != hws_pkg::ST_INIT;
    on_pg = q_ff.st == hws_pkg::ST_ON && q_ff.pg_oe;
    set_c = '0;

    // Overvoltage only once the host turned it on
    set_c[hws_pkg::C_OVP] = q_ff.ovp_en & f[hws_pkg::IN_VOV];

    // Startup limit during self-test and ramp
    if (q_ff.st == hws_pkg::ST_SELF || q_ff.st == hws_pkg::ST_RAMP) begin
      set_c[hws_pkg::C_SU] = su_pick(f[hws_pkg::IN_SU0 +: 3], q_ff.su_sel);
    end

    // Moderate tier: count only while between moderate and severe
    if (on_pg && f[hws_pkg::IN_MOD] && !f[hws_pkg::IN_SEV]) begin
      nxt_q.mod_cnt = q_ff.mod_cnt + 20'h1;
      if (q_ff.mod_cnt >= mod_lim(q_ff.mod_sel) - 20'h1) begin
        set_c[hws_pkg::C_MOD] = 1'b1;
      end
    end else begin
      nxt_q.mod_cnt = 20'h0;
    end

    // Severe tier; its comparator already applies the ratio
    if (on_pg && f[hws_pkg::IN_SEV]) begin
      nxt_q.sev_cnt = q_ff.sev_cnt + 10'h1;
      if (!q_ff.sev_to) begin
        set_c[hws_pkg::C_SEV] = 1'b1;
      end else if (q_ff.sev_cnt >= 10'(hws_pkg::SEV_CYC - 1)) begin
        set_c[hws_pkg::C_SEV] = 1'b1;
      end
    end else begin
      nxt_q.sev_cnt = 10'h0;
    end

    // Safe tier, resistor check and temperature in every state but init
    set_c[hws_pkg::C_SAFE] = run & f[hws_pkg::IN_SAFE];
    // Moderate comparator tracks resistor changes live
    set_c[hws_pkg::C_ROCP] = run & ~f[hws_pkg::IN_ROK];
    set_c[hws_pkg::C_OTP] = run & f[hws_pkg::IN_OTF];

    // External pull-low, watched only after our own drive settled
    if (!q_ff.fault_oe) begin
      nxt_q.ext_hold = 3'h0;
    end else if (q_ff.ext_hold != 3'(hws_pkg::EXT_HOLD)) begin
      nxt_q.ext_hold = q_ff.ext_hold + 3'h1;
    end

    if (run && q_ff.ext_hold == 3'(hws_pkg::EXT_HOLD) && !f[hws_pkg::IN_FLT]) begin
      set_c[hws_pkg::C_EXT] = 1'b1;
    end

    // ****************************************
    // Startup sequencer
    // ****************************************
    nxt_q.tmr = q_ff.tmr + 20'h1;
    unique case (q_ff.st)
      hws_pkg::ST_INIT: begin
        // Enable ignored until the address read is done
        nxt_q.tmr = 20'h0;
        if (f[hws_pkg::IN_RDY]) begin
          nxt_q.st = hws_pkg::ST_IDLE;
        end
      end

      hws_pkg::ST_IDLE: begin
        nxt_q.tmr = 20'h0;
        if (f[hws_pkg::IN_EN] && !q_ff.fault) begin
          nxt_q.st = hws_pkg::ST_DLY;
        end
      end

      hws_pkg::ST_DLY: begin
        if (q_ff.tmr >= 20'(DLY_CYC - 1)) begin
          nxt_q.tmr = 20'h0;
          nxt_q.st = hws_pkg::ST_SELF;
        end
      end

      hws_pkg::ST_SELF: begin
        // Output and soft-start cap must both be low at the end
        if (q_ff.tmr >= 20'(SELF_CYC - 1)) begin
          nxt_q.tmr = 20'h0;
          if (f[hws_pkg::IN_CSS] && f[hws_pkg::IN_VLO]) begin
            nxt_q.st = hws_pkg::ST_RAMP;
          end else begin
            set_c[hws_pkg::C_SELF] = 1'b1;
          end
        end
      end

      hws_pkg::ST_RAMP: begin
        if (f[hws_pkg::IN_VOK] && f[hws_pkg::IN_ENH]) begin
          nxt_q.st = hws_pkg::ST_ON;
        end
      end

      hws_pkg::ST_ON: begin
        nxt_q.tmr = 20'h0;
      end

      default: begin
        nxt_q.st = hws_pkg::ST_IDLE;
      end
    endcase

    // Sticky latch; a new fault wins over a clear in the same cycle
    nxt_q.cause = (q_ff.cause & ~{hws_pkg::NC{clr}}) | set_c;
    nxt_q.fault = (q_ff.fault & ~clr) | (|set_c);

    // Enable low or a fault drops back to idle, non-latching for enable
    if (run && (!f[hws_pkg::IN_EN] || nxt_q.fault || clr)) begin
      nxt_q.st = hws_pkg::ST_IDLE;
    end

    // Outputs from next state so pins move on the same edge
    nxt_q.fet_on = ~nxt_q.fault &
      (nxt_q.st == hws_pkg::ST_RAMP || nxt_q.st == hws_pkg::ST_ON);
    nxt_q.css_dis = nxt_q.st == hws_pkg::ST_SELF;
    nxt_q.fault_oe = ~nxt_q.fault;
    nxt_q.pg_oe = nxt_q.st == hws_pkg::ST_ON && ~nxt_q.fault &&
      f[hws_pkg::IN_VOK] && f[hws_pkg::IN_ENH];

    // Read data; warning is a flag only
    nxt_q.rdat = 32'h0000_0000;
    if (rd) begin
      unique case (wb_adr_i)
        hws_pkg::ADR_CTRL: begin
          nxt_q.rdat[hws_pkg::CB_OVP_EN] = q_ff.ovp_en;
          nxt_q.rdat[hws_pkg::CB_SU_SEL +: 2] = q_ff.su_sel;
          nxt_q.rdat[hws_pkg::CB_MOD_SEL +: 2] = q_ff.mod_sel;
          nxt_q.rdat[hws_pkg::CB_SEV_TO] = q_ff.sev_to;
          nxt_q.rdat[hws_pkg::CB_RATIO +: 3] = q_ff.ratio;
        end

        hws_pkg::ADR_OVP: begin
          nxt_q.rdat[7:0] = q_ff.ovp_lim;
        end

        hws_pkg::ADR_STAT: begin
          nxt_q.rdat[2:0] = q_ff.st;
          nxt_q.rdat[3] = q_ff.fault;
          nxt_q.rdat[4] = q_ff.pg_oe;
          nxt_q.rdat[5] = q_ff.fet_on;
          nxt_q.rdat[6] = f[hws_pkg::IN_OTW];
          nxt_q.rdat[7] = f[hws_pkg::IN_EN];
          nxt_q.rdat[16 +: hws_pkg::NC] = q_ff.cause;
        end
        default: begin
          // Unmapped: ack with zero
          nxt_q.rdat = 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= hws_pkg::REGS_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from flops; drive values are constant low
  assign wb_dat_o = q_ff.rdat;
  assign wb_ack_o = q_ff.ack;
  assign fault_o = 1'b0;
  assign supply_ok_out_o = 1'b0;
  assign fault_oe_o = q_ff.fault_oe;
  assign supply_ok_out_oe_o = q_ff.pg_oe;
  assign fet_on_o = q_ff.fet_on;
  assign softstart_capacitor_dis_o = q_ff.css_dis;

  // Configuration copies for the analog side
  assign input_overvolt_guard_en_o = q_ff.ovp_en;
  assign ovp_limit_o = q_ff.ovp_lim;
  assign su_sel_o = q_ff.su_sel;
  assign sev_ratio_o = q_ff.ratio;
endmodule

// ===== hws_fault_supervisor_sva.sv
// Port-level checks on the fault supervisor, bound into each instance.
// Assumes one clock domain and comparator levels held several cycles.
`timescale 1ns/1ps
module hws_fault_supervisor_sva (
  input wire logic clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire logic enable_lockout_input_i, // Enable level
  input wire logic oc_safe_i, // Safe tier level
  input wire logic fault_i, // Fault line level
  input wire logic fault_oe_o, // Fault enable, low drives
  input wire logic supply_ok_out_oe_o, // Power-good enable
  input wire logic fet_on_o, // Transistor on
  input wire logic softstart_capacitor_dis_o // Soft-start discharge
);
  // ****************************************
  // Defaults
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ****************************************
  // Bus handshake
  // ****************************************
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  data_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  // ****************************************
  // Protection and sequencing
  // ****************************************
  fault_gate_a: assert property (!fault_oe_o |-> !fet_on_o)
    else $error("transistor on while fault latched");
  pg_rise_a: assert property ($rose(supply_ok_out_oe_o) |-> fet_on_o && $past(fet_on_o))
    else $error("power good rose without transistor on");
  safe_trip_a: assert property ($rose(oc_safe_i) ##0 oc_safe_i[*6] |-> ##[0:3] !fault_oe_o && !fet_on_o)
    else $error("safe tier excess did not trip in time");
  ext_trip_a: assert property (fet_on_o && fault_oe_o && !fault_i ##1 !fault_i[*5] |-> ##[0:3] !fault_oe_o)
    else $error("external fault low not latched");
  en_off_a: assert property (!enable_lockout_input_i[*6] |-> ##[0:3] !fet_on_o && !supply_ok_out_oe_o)
    else $error("enable low left transistor or power good on");
  ramp_order_a: assert property ($rose(fet_on_o) |-> $past(softstart_capacitor_dis_o))
    else $error("ramp started without self-test before it");
  // Latch may only open on enable fall or a bus restart
  fault_hold_a: assert property (!fault_oe_o && enable_lockout_input_i && !wb_stb_i |=> !fault_oe_o)
    else $error("fault latch released without restart event");
  up_c: cover property ($rose(supply_ok_out_oe_o));
  trip_c: cover property ($fell(fault_oe_o));
  ext_c: cover property (fault_oe_o && !fault_i);
endmodule
bind hws_fault_supervisor hws_fault_supervisor_sva hws_fault_supervisor_sva_i (.clk_i, .rst_n_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .enable_lockout_input_i, .oc_safe_i, .fault_i, .fault_oe_o,
  .supply_ok_out_oe_o, .fet_on_o, .softstart_capacitor_dis_o);

// ===== hws_fault_supervisor_tb.sv
// Self-checking bench for the fault supervisor with shortened phase counts.
// Assumes the line model and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t mismatch at line %0d", $time, `__LINE__); end end
module hws_fault_supervisor_tb;
  // ****************************************
  // Signals
  // ****************************************
  logic clk_i = 1'b0; // Clock
  logic rst_n_i = 1'b0; // Reset, active low
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0; // Bus controls
  logic [7:0] wb_adr_i = 8'h00; // Address
  logic [3:0] wb_sel_i = 4'h0; // Byte enables
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd; // Bus data, last read
  logic wb_ack_o, fault_o, fault_oe_o, supply_ok_out_o, supply_ok_out_oe_o, fet_on_o; // Outputs
  logic softstart_capacitor_dis_o, input_overvolt_guard_en_o; // Outputs
  logic [7:0] ovp_limit_o; // Limit copy
  logic [1:0] su_sel_o; // Startup select copy
  logic [2:0] sev_ratio_o; // Ratio copy
  logic [hws_pkg::NIN-1:0] cmp; // Comparator levels, package order
  logic fault_line, pg_line; // Resolved open-drain lines
  logic [31:0] ctrl = 32'h0000_0000; // Shadow of control register
  int n_fail = 0, comparisons = 0, cyc = 0; // Counters
  always #5 clk_i = ~clk_i;
  // Hang guard, far above the planned run
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  hws_fault_supervisor #(.DLY_CYC(20), .SELF_CYC(20), .MOD_CYC0(30), .MOD_CYC1(40), .MOD_CYC2(50),
      .MOD_CYC3(60)) hws_fault_supervisor_i (
    .clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .enable_lockout_input_i(cmp[hws_pkg::IN_EN]), .vin_over_i(cmp[hws_pkg::IN_VOV]),
    .su_over_i(cmp[hws_pkg::IN_SU0+:3]), .oc_mod_i(cmp[hws_pkg::IN_MOD]), .oc_sev_i(cmp[hws_pkg::IN_SEV]),
    .oc_safe_i(cmp[hws_pkg::IN_SAFE]), .rocp_ok_i(cmp[hws_pkg::IN_ROK]), .temp_fault_i(cmp[hws_pkg::IN_OTF]),
    .temp_warn_i(cmp[hws_pkg::IN_OTW]), .vout_good_i(cmp[hws_pkg::IN_VOK]), .fet_enh_i(cmp[hws_pkg::IN_ENH]),
    .css_low_i(cmp[hws_pkg::IN_CSS]), .vout_low_i(cmp[hws_pkg::IN_VLO]), .init_done_i(cmp[hws_pkg::IN_RDY]),
    .fault_i(fault_line), .fault_o, .fault_oe_o, .supply_ok_out_o, .supply_ok_out_oe_o, .fet_on_o,
    .softstart_capacitor_dis_o, .input_overvolt_guard_en_o, .ovp_limit_o, .su_sel_o, .sev_ratio_o);
  hws_line_model hws_line_model_i (.fault_oe_i(fault_oe_o), .pg_oe_i(supply_ok_out_oe_o),
    .ext_low_i(cmp[hws_pkg::IN_FLT]), .fault_line_o(fault_line), .pg_line_o(pg_line));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Classic cycle: hold until ack, then one idle cycle
  task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wait_flt(output int n);
    n = 0;
    while (fault_oe_o !== 1'b0 && n < 1200) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // Startup must pass through self-test before power good
  task automatic up();
    int n = 0;
    bit seen = 0;
    while (pg_line !== 1'b1 && n < 200) begin
      @(posedge clk_i);
      n++;
      seen |= softstart_capacitor_dis_o === 1'b1;
    end
    `CHK(seen && n > 40 && n < 200, 1'b1)
  endtask
  // Clear by enable toggle or by restart write
  task automatic clr(input bit by_en);
    if (by_en) begin
      cmp[hws_pkg::IN_EN] <= 1'b0;
      repeat (10) @(posedge clk_i);
      `CHK({fault_oe_o, fet_on_o, pg_line, fault_o, supply_ok_out_o}, 5'b10000)
      cmp[hws_pkg::IN_EN] <= 1'b1;
    end else begin
      wbx(1'b1, hws_pkg::ADR_CTRL, ctrl | 32'h0000_0080);
    end
    up();
  endtask
  // Source trips, is removed, latch holds until cleared
  task automatic trip(input int b, input logic v, input int c, input bit by_en);
    cmp[b] <= v;
    repeat (8) @(posedge clk_i);
    `CHK({fault_oe_o, fet_on_o, pg_line}, 3'b000)
    cmp[b] <= ~v;
    repeat (30) @(posedge clk_i);
    `CHK(fault_oe_o, 1'b0)
    wbx(1'b0, hws_pkg::ADR_STAT, 32'h0000_0000);
    `CHK(rd[16 + c] & rd[3], 1'b1)
    clr(by_en);
  endtask
  // Short excess must not trip; full excess trips near the limit
  task automatic timed(input int b, input int lim);
    int n;
    cmp[b] <= 1'b1;
    repeat (lim - 8) @(posedge clk_i);
    cmp[b] <= 1'b0;
    repeat (10) @(posedge clk_i);
    `CHK(fault_oe_o, 1'b1)
    cmp[b] <= 1'b1;
    wait_flt(n);
    cmp[b] <= 1'b0;
    `CHK(n >= lim && n <= lim + 7, 1'b1)
    clr(1'b0);
  endtask
  // A discharge check left low at the end of self-test latches
  task automatic self_fail(input int b);
    int n;
    cmp[b] <= 1'b0;
    cmp[hws_pkg::IN_EN] <= 1'b0;
    repeat (10) @(posedge clk_i);
    cmp[hws_pkg::IN_EN] <= 1'b1;
    wait_flt(n);
    cmp[b] <= 1'b1;
    wbx(1'b0, hws_pkg::ADR_STAT, 32'h0000_0000);
    `CHK({rd[16 + hws_pkg::C_SELF], fet_on_o, n > 40 && n < 60}, 3'b101)
    clr(1'b1);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int n;
    cmp = '0;
    cmp[hws_pkg::IN_EN] = 1'b1;
    cmp[hws_pkg::IN_ROK] = 1'b1;
    cmp[hws_pkg::IN_VOK] = 1'b1;
    cmp[hws_pkg::IN_ENH] = 1'b1;
    cmp[hws_pkg::IN_CSS] = 1'b1;
    cmp[hws_pkg::IN_VLO] = 1'b1;
    cmp[hws_pkg::IN_VOV] = 1'b1;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    // Enable high but init not done: must stay in init
    wbx(1'b0, hws_pkg::ADR_STAT, 32'h0000_0000);
    `CHK({rd[2:0], fet_on_o}, 4'h0)
    wbx(1'b0, hws_pkg::ADR_CTRL, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    wbx(1'b0, hws_pkg::ADR_OVP, 32'h0000_0000);
    `CHK(rd[7:0], hws_pkg::OVP_RST)
    wbx(1'b0, 8'h0c, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    cmp[hws_pkg::IN_RDY] <= 1'b1;
    up();
    `CHK({fault_oe_o, input_overvolt_guard_en_o}, 2'b10)
    cmp[hws_pkg::IN_VOV] <= 1'b0;
    clr(1'b1);
    trip(hws_pkg::IN_SAFE, 1'b1, hws_pkg::C_SAFE, 1'b0);
    trip(hws_pkg::IN_ROK, 1'b0, hws_pkg::C_ROCP, 1'b1);
    trip(hws_pkg::IN_OTF, 1'b1, hws_pkg::C_OTP, 1'b0);
    trip(hws_pkg::IN_SEV, 1'b1, hws_pkg::C_SEV, 1'b1);
    trip(hws_pkg::IN_FLT, 1'b1, hws_pkg::C_EXT, 1'b0);
    ctrl = 32'h0000_0501;
    wbx(1'b1, hws_pkg::ADR_CTRL, ctrl);
    wbx(1'b1, hws_pkg::ADR_OVP, 32'h0000_00a5);
    `CHK({input_overvolt_guard_en_o, sev_ratio_o, ovp_limit_o}, 12'hda5)
    trip(hws_pkg::IN_VOV, 1'b1, hws_pkg::C_OVP, 1'b1);
    cmp[hws_pkg::IN_OTW] <= 1'b1;
    repeat (30) @(posedge clk_i);
    wbx(1'b0, hws_pkg::ADR_STAT, 32'h0000_0000);
    `CHK({fault_oe_o, fet_on_o, rd[6]}, 3'b111)
    cmp[hws_pkg::IN_OTW] <= 1'b0;
    self_fail(hws_pkg::IN_CSS);
    self_fail(hws_pkg::IN_VLO);
    for (int s = 0; s < 4; s++) begin
      ctrl[4:3] = s[1:0];
      wbx(1'b1, hws_pkg::ADR_CTRL, ctrl);
      timed(hws_pkg::IN_MOD, 30 + 10 * s);
    end
    ctrl[5] = 1'b1;
    wbx(1'b1, hws_pkg::ADR_CTRL, ctrl);
    timed(hws_pkg::IN_SEV, hws_pkg::SEV_CYC);
    // Hold in ramp with moderate and unselected startup limit high
    ctrl[2:1] = 2'b01;
    wbx(1'b1, hws_pkg::ADR_CTRL, ctrl);
    `CHK(su_sel_o, 2'b01)
    cmp[hws_pkg::IN_VOK] <= 1'b0;
    cmp[hws_pkg::IN_MOD] <= 1'b1;
    cmp[hws_pkg::IN_SU0] <= 1'b1;
    cmp[hws_pkg::IN_EN] <= 1'b0;
    repeat (10) @(posedge clk_i);
    cmp[hws_pkg::IN_EN] <= 1'b1;
    repeat (120) @(posedge clk_i);
    `CHK({fault_oe_o, fet_on_o}, 2'b11)
    cmp[hws_pkg::IN_SU0 + 1] <= 1'b1;
    wait_flt(n);
    `CHK(n <= 1000, 1'b1)
    cmp[hws_pkg::IN_SU0+:3] <= 3'h0;
    cmp[hws_pkg::IN_MOD] <= 1'b0;
    cmp[hws_pkg::IN_VOK] <= 1'b1;
    clr(1'b0);
    results();
  end
endmodule

// ===== hws_line_model.sv
// Far-side model: pull-ups on both open-drain lines and an external fault source.
// Assumes the supervisor's enables are low while it pulls a line low.
`timescale 1ns/1ps
module hws_line_model (
  input wire logic fault_oe_i, // Device fault enable, low drives
  input wire logic pg_oe_i, // Device power-good enable, low drives
  input wire logic ext_low_i, // External circuitry pulls fault low
  output logic fault_line_o, // Resolved fault line
  output logic pg_line_o // Resolved power-good line
);
  // ****************************************
  // Wired-AND of open-drain parties
  // ****************************************
  // Pull-up wins only while nobody pulls low
  assign fault_line_o = fault_oe_i & ~ext_low_i;
  // Released line floats up to the pull-up rail
  assign pg_line_o = pg_oe_i;
endmodule

// ===== hws_pkg.sv
// Constants, types and state layout of the hot-swap fault supervisor.
// Assumes a 100 MHz clock and comparator levels from the analog front end.
package hws_pkg;
  // ****************************************
  // Register map, byte addresses
  // ****************************************
  localparam logic [7:0] ADR_CTRL = 8'h00; // Control
  localparam logic [7:0] ADR_OVP = 8'h04; // Overvoltage limit
  localparam logic [7:0] ADR_STAT = 8'h08; // Status, read only
  // Control fields
  localparam int CB_OVP_EN = 0; // Overvoltage guard enable
  localparam int CB_SU_SEL = 1; // Startup limit select, 2 bits
  localparam int CB_MOD_SEL = 3; // Moderate timeout select, 2 bits
  localparam int CB_SEV_TO = 5; // Severe timeout enable
  localparam int CB_RESTART = 7; // Write one to restart
  localparam int CB_RATIO = 8; // Severe ratio, 3 bits
  localparam logic [2:0] RATIO_RST = 3'h0; // Severe ratio reset
  localparam logic [7:0] OVP_RST = 8'h00; // Overvoltage limit reset
  // ****************************************
  // Comparator input indices
  // ****************************************
  localparam int IN_EN = 0; // Enable above threshold
  localparam int IN_VOV = 1; // Input above overvoltage limit
  localparam int IN_SU0 = 2; // Startup limits 0..2 at 2..4
  localparam int IN_MOD = 5; // Above moderate threshold
  localparam int IN_SEV = 6; // Above severe threshold
  localparam int IN_SAFE = 7; // Above safe threshold
  localparam int IN_ROK = 8; // Program resistor in range
  localparam int IN_OTF = 9; // Temperature above fault limit
  localparam int IN_OTW = 10; // Temperature above warning limit
  localparam int IN_VOK = 11; // Output above good threshold
  localparam int IN_ENH = 12; // Transistor fully enhanced
  localparam int IN_CSS = 13; // Soft-start capacitor discharged
  localparam int IN_VLO = 14; // Output below self-check level
  localparam int IN_RDY = 15; // Address read and boost done
  localparam int IN_FLT = 16; // Fault line level
  localparam int NIN = 17; // Number of inputs
  // Fault cause bits
  localparam int C_OVP = 0;
  localparam int C_SU = 1;
  localparam int C_MOD = 2;
  localparam int C_SEV = 3;
  localparam int C_SAFE = 4;
  localparam int C_ROCP = 5;
  localparam int C_OTP = 6;
  localparam int C_EXT = 7;
  localparam int C_SELF = 8;
  localparam int NC = 9;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS = 10; // Clock period
  localparam int SEV_TO_NS = 10000; // Severe tolerance window
  localparam int SEV_CYC = (SEV_TO_NS + CLK_NS - 1) / CLK_NS;
  localparam int MOD_US [4] = '{100, 200, 500, 1000}; // Timeouts
  localparam int DLY_US = 1000; // Startup delay
  localparam int SELF_US = 1000; // Self-test time
  localparam int EXT_HOLD = 7; // Settle cycles after release
  typedef enum logic [2:0] {
    ST_INIT = 3'h0, ST_IDLE = 3'h1, ST_DLY = 3'h2,
    ST_SELF = 3'h3, ST_RAMP = 3'h4, ST_ON = 3'h5
  } hws_st_t;
  typedef struct packed {
    logic [NIN-1:0] s1, s2, s3, flt; // Sync chain, filtered
    hws_st_t st; // Sequencer state
    logic [19:0] tmr; // Phase timer
    logic [19:0] mod_cnt; // Moderate timeout count
    logic [9:0] sev_cnt; // Severe window count
    logic [2:0] ext_hold; // Release settle count
    logic fault; // Sticky fault latch
    logic [NC-1:0] cause; // Latched causes
    logic en_prev; // Enable last cycle
    logic ovp_en, sev_to; // Control bits
    logic [1:0] su_sel, mod_sel; // Control selects
    logic [2:0] ratio; // Severe ratio
    logic [7:0] ovp_lim; // Overvoltage limit
    logic fet_on, css_dis; // Transistor, discharge
    logic fault_oe, pg_oe; // Open-drain enables
    logic ack; // Bus ack
    logic [31:0] rdat; // Bus read data
  } hws_regs_t;
  localparam hws_regs_t REGS_RST = '{fault_oe: 1'b1, st: ST_INIT,
    ratio: RATIO_RST, ovp_lim: OVP_RST, default: '0};
endpackage
